/* rtl/iop_defs.svh */
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IOP_ADDR_W      12
`define IOP_BANK_W      4
`define IOP_DATA_W      8
`define IOP_PC_W        21
`define IOP_LIT_W       6
`define IOP_NUM_PTR     3

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define IOP_OPC_HI      15
`define IOP_OPC_LO      8
`define IOP_SEL_HI      7
`define IOP_SEL_LO      6
`define IOP_LIT_HI      5
`define IOP_LIT_LO      0
`define IOP_FILE_HI     7
`define IOP_FILE_LO     0
`define IOP_ACCESS_BIT  8
`define IOP_DEST_BIT    9
`define IOP_SUB_OPCODE  8'he9
`define IOP_SEL_RETURN  2'h3
`define IOP_FRAME_SEL   2'h2

// ----------------------------------------------------------------
// Addressing and reset values
// ----------------------------------------------------------------
`define IOP_OFFSET_MAX  8'h5f
`define IOP_ACC_LOW     4'h0
`define IOP_ACC_HIGH    4'hf
`define IOP_PTR_RESET   12'h000
`define IOP_PC_RESET    21'h000000
`define IOP_DATA_RESET  8'h00

// ----------------------------------------------------------------
// Timing: clock periods in one instruction cycle
// ----------------------------------------------------------------
`define IOP_PHASES      4
`define IOP_Q1          2'h0
`define IOP_Q2          2'h1
`define IOP_Q3          2'h2
`define IOP_Q4          2'h3

`endif

/* rtl/iop_pkg.sv */
`default_nettype none
`include "iop_defs.svh"

package iop_pkg;

  typedef enum logic [1:0] {
    op_idle,
    op_sub,
    op_subret,
    op_file
  } iop_op_type;

  typedef logic [`IOP_NUM_PTR-1:0][`IOP_ADDR_W-1:0] iop_ptr_type;

  typedef struct packed {
    iop_op_type                op;
    logic [1:0]                phase;
    logic                      second;
    logic [1:0]                sel;
    logic [`IOP_LIT_W-1:0]     lit;
    iop_ptr_type               ptr;
    logic [`IOP_ADDR_W-1:0]    addr;
    logic                      indexed;
    logic                      dest_file;
    logic [`IOP_DATA_W-1:0]    operand;
    logic [`IOP_DATA_W-1:0]    wdata;
    logic                      mem_rd;
    logic                      mem_wr;
    logic                      wreg_wr;
    logic                      pc_load;
    logic [`IOP_PC_W-1:0]      pc;
  } iop_state_type;

endpackage : iop_pkg

`default_nettype wire

/* rtl/iop_addr_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"

interface iop_addr_if;
  logic [`IOP_FILE_HI:0]    file_operand;
  logic                     access;
  logic                     ext_enable;
  logic [`IOP_ADDR_W-1:0]   frame;
  logic [`IOP_BANK_W-1:0]   bank;
  logic [`IOP_ADDR_W-1:0]   eff_addr;
  logic                     indexed;

  modport resolver (
    input  file_operand,
    input  access,
    input  ext_enable,
    input  frame,
    input  bank,
    output eff_addr,
    output indexed
  );

  modport user (
    output file_operand,
    output access,
    output ext_enable,
    output frame,
    output bank,
    input  eff_addr,
    input  indexed
  );
endinterface : iop_addr_if

`default_nettype wire

/* rtl/iop_addr_resolve.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"

module iop_addr_resolve (
  iop_addr_if.resolver ar
);

  // --------------------------------------------------------------
  // Effective address
  // --------------------------------------------------------------
  logic low_operand;

  always_comb begin
    low_operand = (ar.file_operand <= `IOP_OFFSET_MAX);
    ar.indexed  = ar.ext_enable && !ar.access && low_operand;
    if (ar.indexed) begin
      // Frame of zero gives the plain low access bank
      ar.eff_addr = ar.frame + {`IOP_ACC_LOW, ar.file_operand};
    end else if (ar.access) begin
      ar.eff_addr = {ar.bank, ar.file_operand};
    end else if (low_operand) begin
      ar.eff_addr = {`IOP_ACC_LOW, ar.file_operand};
    end else begin
      // High operands stay literal in either mode
      ar.eff_addr = {`IOP_ACC_HIGH, ar.file_operand};
    end
  end

endmodule : iop_addr_resolve

`default_nettype wire

/* rtl/iop_core.sv */
// Function
// - Pointer subtract removes 6-bit literal, no flags
// - Opcode E9h with selector; selector 3 returns
// - Frame subtract, then load PC from stack
// - Return form two cycles; plain form one
// - Extended set also enables offset addressing
// - Disabled: access bank or bank register
// - Enabled, access 0, operand <=5Fh: frame offset
// - Applies to byte/bit ops; high operands literal
// - Destination bit keeps normal meaning
// - Frame zero matches original access bank
// - Indexed read, process, write in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"

module iop_core (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire logic                         clock_enable,
  // Configuration
  input  wire logic                         extended_enable,
  // Instruction issue
  input  wire logic                         instr_valid,
  output logic                              instr_ready,
  input  wire logic [15:0]                  instr_word,
  input  wire logic                         file_op,
  input  wire logic                         bit_op,
  // Bank select
  input  wire logic [`IOP_BANK_W-1:0]       bank_select_value,
  // Return stack and program counter
  input  wire logic [`IOP_PC_W-1:0]         return_stack_top,
  output logic                              pc_load,
  output logic [`IOP_PC_W-1:0]              pc_value,
  output logic                              stack_pop,
  // Data memory
  output logic [`IOP_ADDR_W-1:0]            mem_addr,
  output logic                              mem_read,
  output logic                              mem_write,
  output logic [`IOP_DATA_W-1:0]            mem_wdata,
  input  wire logic [`IOP_DATA_W-1:0]       mem_rdata,
  // Arithmetic unit and working register
  output logic [`IOP_DATA_W-1:0]            alu_operand,
  input  wire logic [`IOP_DATA_W-1:0]       alu_result,
  output logic                              wreg_write,
  output logic [`IOP_DATA_W-1:0]            wreg_data,
  // Pointer and status
  output iop_pkg::iop_ptr_type              indirect_pointer,
  output logic [`IOP_ADDR_W-1:0]            stack_frame_pointer,
  output logic                              indexed_access,
  output logic [1:0]                        q_phase
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  iop_pkg::iop_state_type state;
  iop_pkg::iop_state_type next_state;

  iop_addr_if ar ();

  // --------------------------------------------------------------
  // Operand resolution
  // --------------------------------------------------------------
  // The enable is read live at every decode, so flipping it only
  // changes how the next instruction resolves; nothing is flushed.
  assign ar.file_operand = instr_word[`IOP_FILE_HI:`IOP_FILE_LO];
  assign ar.access       = instr_word[`IOP_ACCESS_BIT];
  assign ar.ext_enable   = extended_enable;
  assign ar.frame        = state.ptr[`IOP_FRAME_SEL];
  assign ar.bank         = bank_select_value;

  iop_addr_resolve u_resolve (
    .ar (ar)
  );

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  logic                    is_sub_family;
  logic [1:0]              dec_sel;
  logic [`IOP_LIT_W-1:0]   dec_lit;
  logic                    accept;

  always_comb begin
    is_sub_family = (instr_word[`IOP_OPC_HI:`IOP_OPC_LO]
                     == `IOP_SUB_OPCODE);
    dec_sel       = instr_word[`IOP_SEL_HI:`IOP_SEL_LO];
    dec_lit       = instr_word[`IOP_LIT_HI:`IOP_LIT_LO];
  end

  // Issue only at the start of an instruction cycle, never in the
  // filler cycle after a return.
  assign instr_ready = (state.phase == `IOP_Q1) && !state.second;
  assign accept      = instr_valid && instr_ready;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    next_state         = state;
    next_state.mem_rd  = 1'b0;
    next_state.mem_wr  = 1'b0;
    next_state.wreg_wr = 1'b0;
    next_state.pc_load = 1'b0;
    next_state.phase   = state.phase + 2'h1;

    case (state.phase)
      `IOP_Q1: begin
        if (accept) begin
          if (is_sub_family) begin
            next_state.lit = dec_lit;
            if (dec_sel == `IOP_SEL_RETURN) begin
              // Return form always works on the frame pointer
              next_state.op  = iop_pkg::op_subret;
              next_state.sel = `IOP_FRAME_SEL;
            end else begin
              next_state.op  = iop_pkg::op_sub;
              next_state.sel = dec_sel;
            end
          end else if (file_op) begin
            next_state.op        = iop_pkg::op_file;
            next_state.addr      = ar.eff_addr;
            next_state.indexed   = ar.indexed;
            // Bit ops always write the register back
            next_state.dest_file = bit_op
                                   || instr_word[`IOP_DEST_BIT];
          end else begin
            next_state.op = iop_pkg::op_idle;
          end
        end
      end

      `IOP_Q2: begin
        if (state.op == iop_pkg::op_file) begin
          next_state.mem_rd = 1'b1;
        end
      end

      `IOP_Q3: begin
        if (state.op == iop_pkg::op_file) begin
          next_state.operand = mem_rdata;
        end
      end

      `IOP_Q4: begin
        case (state.op)
          iop_pkg::op_sub: begin
            // Selector 3 never lands here; flags are not touched
            next_state.ptr[state.sel] =
              state.ptr[state.sel]
              - {{(`IOP_ADDR_W-`IOP_LIT_W){1'b0}}, state.lit};
          end
          iop_pkg::op_subret: begin
            next_state.ptr[`IOP_FRAME_SEL] =
              state.ptr[`IOP_FRAME_SEL]
              - {{(`IOP_ADDR_W-`IOP_LIT_W){1'b0}}, state.lit};
            next_state.pc      = return_stack_top;
            next_state.pc_load = 1'b1;
            next_state.second  = 1'b1;
          end
          iop_pkg::op_file: begin
            next_state.wdata = alu_result;
            if (state.dest_file) begin
              next_state.mem_wr = 1'b1;
            end else begin
              next_state.wreg_wr = 1'b1;
            end
          end
          default: begin
            next_state.op = iop_pkg::op_idle;
          end
        endcase
        next_state.op = iop_pkg::op_idle;
        // Filler cycle after a return ends here as a no-operation
        if (state.second) begin
          next_state.second = 1'b0;
        end
      end

      default: begin
        next_state.phase = `IOP_Q1;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state.op        <= iop_pkg::op_idle;
      state.phase     <= `IOP_Q1;
      state.second    <= 1'b0;
      state.sel       <= 2'h0;
      state.lit       <= {`IOP_LIT_W{1'b0}};
      state.ptr       <= {`IOP_NUM_PTR{`IOP_PTR_RESET}};
      state.addr      <= `IOP_PTR_RESET;
      state.indexed   <= 1'b0;
      state.dest_file <= 1'b0;
      state.operand   <= `IOP_DATA_RESET;
      state.wdata     <= `IOP_DATA_RESET;
      state.mem_rd    <= 1'b0;
      state.mem_wr    <= 1'b0;
      state.wreg_wr   <= 1'b0;
      state.pc_load   <= 1'b0;
      state.pc        <= `IOP_PC_RESET;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Address is held for the whole cycle so a write lands at the
  // location that was read.
  assign mem_addr            = state.addr;
  assign mem_read            = state.mem_rd;
  assign mem_write           = state.mem_wr;
  assign mem_wdata           = state.wdata;
  assign alu_operand         = state.operand;
  assign wreg_write          = state.wreg_wr;
  assign wreg_data           = state.wdata;
  assign pc_load             = state.pc_load;
  assign pc_value            = state.pc;
  assign stack_pop           = state.pc_load;
  assign indirect_pointer    = state.ptr;
  assign stack_frame_pointer = state.ptr[`IOP_FRAME_SEL];
  assign indexed_access      = state.indexed;
  assign q_phase             = state.phase;

endmodule : iop_core

`default_nettype wire

/* rtl/_unused_guard.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verification/iop_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module iop_core_monitor (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 reset_n,
  // Inputs of the core
  input wire logic                 clock_enable,
  input wire logic                 extended_enable,
  input wire logic                 instr_valid,
  input wire logic [15:0]          instr_word,
  input wire logic                 file_op,
  input wire logic                 bit_op,
  input wire logic [3:0]           bank_select_value,
  input wire logic [20:0]          return_stack_top,
  input wire logic [7:0]           alu_result,
  // Outputs of the core
  input wire logic                 instr_ready,
  input wire logic                 pc_load,
  input wire logic                 stack_pop,
  input wire logic [20:0]          pc_value,
  input wire logic [11:0]          mem_addr,
  input wire logic                 mem_read,
  input wire logic                 mem_write,
  input wire logic [7:0]           mem_wdata,
  input wire logic                 wreg_write,
  input wire iop_pkg::iop_ptr_type indirect_pointer,
  input wire logic                 indexed_access
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] op;
  logic       low;
  logic       dfile;
  assign op    = instr_word[7:0];
  assign low   = !instr_word[8] && op <= 8'h5f;
  assign dfile = instr_word[9] || bit_op;
  // --------------------------------------------------------------
  // Accepted requests
  // --------------------------------------------------------------
  sequence s_acc;
    clock_enable && instr_valid && instr_ready;
  endsequence
  sequence s_file;
    s_acc ##0 file_op;
  endsequence
  sequence s_sub;
    s_acc ##0 (instr_word[15:8] == 8'he9 && instr_word[7:6] != 2'h3);
  endsequence
  sequence s_ret;
    s_acc ##0 (instr_word[15:6] == {8'he9, 2'h3});
  endsequence
  property p_sub;
    logic [1:0]  s;
    logic [11:0] v;
    (s_sub, s = instr_word[7:6],
     v = indirect_pointer[instr_word[7:6]] - {6'h0, instr_word[5:0]})
      |-> ##4 (indirect_pointer[s] == v && !pc_load);
  endproperty
  property p_ret;
    logic [11:0] v;
    (s_ret, v = indirect_pointer[2] - {6'h0, instr_word[5:0]})
      |-> ##4 indirect_pointer[2] == v;
  endproperty
  a_sub_pointer: assert property (p_sub)
    else $error("pointer subtract wrong");
  a_sub_single: assert property (s_sub |-> ##4 instr_ready)
    else $error("subtract not single cycle");
  a_ret_frame: assert property (p_ret)
    else $error("frame subtract wrong");
  property p_ret_pc;
    s_ret |-> ##4 (pc_load && stack_pop
                   && pc_value == $past(return_stack_top));
  endproperty
  // Read strobe rises one clock after the address, for one clock
  property p_read;
    s_file |=> !mem_read ##1 mem_read ##1 !mem_read;
  endproperty
  property p_index;
    s_file ##0 (extended_enable && low) |=> (indexed_access
      && mem_addr == $past(indirect_pointer[2]) + {4'h0, $past(op)});
  endproperty
  property p_literal;
    s_file ##0 !(extended_enable && low) |=> (!indexed_access
      && mem_addr == ($past(instr_word[8])
                      ? {$past(bank_select_value), $past(op)}
                      : {($past(op) > 8'h5f) ? 4'hf : 4'h0, $past(op)}));
  endproperty
  property p_dest;
    s_file |-> ##4 (mem_write == $past(dfile, 4)
                    && wreg_write != $past(dfile, 4));
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return load wrong");
  a_ret_filler: assert property (s_ret |-> ##4 !instr_ready ##4 instr_ready)
    else $error("return filler cycle wrong");
  a_file_read: assert property (p_read)
    else $error("read strobe wrong");
  a_index_addr: assert property (p_index)
    else $error("indexed address wrong");
  a_literal_addr: assert property (p_literal)
    else $error("literal address wrong");
  a_dest_select: assert property (p_dest)
    else $error("destination wrong");
  a_write_data: assert property (s_file ##0 dfile |-> ##4 mem_wdata == $past(alu_result))
    else $error("write data wrong");
endmodule : iop_core_monitor

bind iop_core iop_core_monitor mon (
  .clock, .reset_n, .clock_enable, .extended_enable, .instr_valid,
  .instr_word, .file_op, .bit_op, .bank_select_value, .return_stack_top,
  .alu_result, .instr_ready, .pc_load, .stack_pop, .pc_value, .mem_addr,
  .mem_read, .mem_write, .mem_wdata, .wreg_write, .indirect_pointer,
  .indexed_access
);
`default_nettype wire

/* verification/indexed_offset_pointer_ops_test.sv */
`timescale 1ns/1ps
`default_nettype none
module indexed_offset_pointer_ops_test;
  typedef struct packed {
    logic e; logic [15:0] w; logic f; logic b; logic [3:0] k;
  } iop_row_type;
  logic        clock, reset_n, clock_enable, extended_enable, prev_ret;
  logic        instr_valid, file_op, bit_op, instr_ready, indexed_access;
  logic        pc_load, stack_pop, mem_read, mem_write, wreg_write;
  logic [15:0] instr_word;
  logic [3:0]  bank_select_value;
  logic [20:0] return_stack_top, pc_value;
  logic [11:0] mem_addr, stack_frame_pointer;
  logic [7:0]  mem_rdata, alu_result, mem_wdata, alu_operand, wreg_data;
  logic [1:0]  q_phase;
  iop_pkg::iop_ptr_type indirect_pointer, mp;
  iop_row_type rows [15];
  int          bad_count, total_checks;

  iop_core uut (
    .clock, .reset_n, .clock_enable, .extended_enable, .instr_valid,
    .instr_ready, .instr_word, .file_op, .bit_op, .bank_select_value,
    .return_stack_top, .pc_load, .pc_value, .stack_pop, .mem_addr,
    .mem_read, .mem_write, .mem_wdata, .mem_rdata, .alu_operand,
    .alu_result, .wreg_write, .wreg_data, .indirect_pointer,
    .stack_frame_pointer, .indexed_access, .q_phase
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------
  // One instruction, walked edge by edge
  // --------------------------------------------------------------
  task automatic exec(input iop_row_type r);
    logic [11:0] ea;
    logic [7:0]  rd, res;
    logic        ret, wf, ix;
    int          n;
    rd  = r.w[7:0] ^ 8'h3c;
    ix  = r.e && !r.w[8] && r.w[7:0] <= 8'h5f;
    res = rd + 8'h11;
    ret = r.w[15:6] == {8'he9, 2'h3};
    wf  = r.w[9] || r.b;
    n   = 0;
    while (instr_ready !== 1'b1 && n < 12) begin
      @(posedge clock);
      #2;
      n++;
    end
    if (prev_ret) chk(n, 4);
    extended_enable   = r.e;
    bank_select_value = r.k;
    instr_word        = r.w;
    file_op           = r.f;
    bit_op            = r.b;
    instr_valid       = 1'b1;
    mem_rdata         = rd;
    alu_result        = res;
    // A fresh return target per word, so a stale load is caught
    return_stack_top  = {5'h0a, r.w};
    if (r.w[8]) ea = {r.k, r.w[7:0]};
    else if (r.w[7:0] > 8'h5f) ea = {4'hf, r.w[7:0]};
    else ea = r.e ? mp[2] + {4'h0, r.w[7:0]} : {4'h0, r.w[7:0]};
    @(posedge clock);
    #2;
    instr_valid = 1'b0;
    if (r.f) chk(mem_addr, ea);
    if (r.f) chk(indexed_access, ix);
    @(posedge clock);
    #2;
    if (r.f) chk(mem_read, 1'b1);
    @(posedge clock);
    #2;
    if (r.f) chk(alu_operand, rd);
    @(posedge clock);
    #2;
    if (r.f) chk({mem_write, wreg_write}, wf ? 2'h2 : 2'h1);
    if (r.f) chk(wf ? mem_wdata : wreg_data, res);
    if (r.w[15:8] == 8'he9) mp[ret ? 2'h2 : r.w[7:6]] -= {6'h0, r.w[5:0]};
    chk(indirect_pointer, mp);
    chk(stack_frame_pointer, mp[2]);
    chk({pc_load, stack_pop}, {ret, ret});
    if (ret) chk(pc_value, return_stack_top);
    prev_ret = ret;
  endtask : exec

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    clock_enable = 1'b1; extended_enable = 1'b0; instr_valid = 1'b0;
    instr_word = 16'h0000; file_op = 1'b0; bit_op = 1'b0;
    bank_select_value = 4'h0; return_stack_top = 21'h0abcde;
    mem_rdata = 8'h00; alu_result = 8'h00; reset_n = 1'b0;
    bad_count = 0; total_checks = 0; prev_ret = 1'b0; mp = '0;
    rows = '{
      '{1'b0, 16'he93f, 1'b0, 1'b0, 4'h0}, '{1'b0, 16'he981, 1'b0, 1'b0, 4'h0},
      '{1'b0, 16'he97f, 1'b0, 1'b0, 4'h0}, '{1'b0, 16'he900, 1'b0, 1'b0, 4'h0},
      '{1'b0, 16'h0220, 1'b1, 1'b0, 4'h0}, '{1'b0, 16'h0345, 1'b1, 1'b0, 4'h5},
      '{1'b0, 16'h0060, 1'b1, 1'b0, 4'h0}, '{1'b1, 16'h005f, 1'b1, 1'b0, 4'h0},
      '{1'b1, 16'h0260, 1'b1, 1'b0, 4'h0}, '{1'b1, 16'h0110, 1'b1, 1'b0, 4'ha},
      '{1'b1, 16'h0c00, 1'b1, 1'b1, 4'h0}, '{1'b1, 16'h0000, 1'b0, 1'b0, 4'h0},
      '{1'b1, 16'he9c5, 1'b0, 1'b0, 4'h0}, '{1'b0, 16'he9ff, 1'b0, 1'b0, 4'h0},
      '{1'b0, 16'he942, 1'b0, 1'b0, 4'h0}};
    repeat (3) @(posedge clock);
    #2;
    chk(instr_ready, 1'b1);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      exec(rows[i]);
      $display("row %0d done", i);
    end
    // Freeze: phase and pointers must hold while the enable is low
    clock_enable = 1'b0;
    repeat (3) @(posedge clock);
    #2;
    chk({q_phase, indirect_pointer}, {2'h0, mp});
    clock_enable = 1'b1;
    $display("freeze test done");
    // Second reset in mid-run, then a zero frame gives legacy addresses
    reset_n = 1'b0;
    #1;
    chk({indirect_pointer, pc_load, mem_read}, '0);
    repeat (3) @(posedge clock);
    #2;
    reset_n  = 1'b1;
    mp       = '0;
    prev_ret = 1'b0;
    exec('{1'b1, 16'h0230, 1'b1, 1'b0, 4'h0});
    chk(mem_addr, 12'h030);
    $display("reset test done");
    wrap_up();
  end

  // About 80 cycles of work; a thousand leaves ample margin
  initial begin
    #50000;
    bad_count++;
    wrap_up();
  end
endmodule : indexed_offset_pointer_ops_test
`default_nettype wire
